// *** include/phy_timing_pkg.sv ***
// ----------------------------------------------------------------
// shared constants and carriers
// ----------------------------------------------------------------
package phy_timing_pkg;
    localparam int CLK_NS        = 10;
    // bit times per line rate
    localparam int BIT_NS_FAST   = 10;
    localparam int BIT_NS_SLOW   = 100;
    localparam int CPB_FAST      = BIT_NS_FAST / CLK_NS;
    localparam int CPB_SLOW      = BIT_NS_SLOW / CLK_NS;
    // host clock periods per mode
    localparam int PER_NS_MII_F  = 40;
    localparam int PER_NS_MII_S  = 400;
    localparam int PER_NS_SYM_F  = 40;
    localparam int PER_NS_SER_S  = 100;
    localparam int BITS_PER_NIB  = 4;
    localparam int SER_TX_DLY_BT = 8;
    localparam logic [3:0] ERR_NIB = 4'hf;
    // management clock limits
    localparam int MDC_HI_NS     = 160;
    localparam int MDC_LO_NS     = 160;
    localparam int MDC_PER_NS    = 400;
    localparam int MDC_HI_CYC    = (MDC_HI_NS + CLK_NS - 1) / CLK_NS;
    localparam int MDC_LO_CYC    = (MDC_LO_NS + CLK_NS - 1) / CLK_NS;
    localparam int MDC_PER_CYC   = (MDC_PER_NS + CLK_NS - 1) / CLK_NS;
    localparam int FIFO_DEPTH    = 32;

    typedef enum logic [1:0] {
        MODE_MII_FAST,
        MODE_MII_SLOW,
        MODE_SYM_FAST,
        MODE_SER_SLOW
    } mode_e;

    typedef struct packed {
        logic [3:0] txd;
        logic       en;
        logic       er;
    } tx_pins_s;

    typedef struct packed {
        logic [3:0] rxd;
        logic       dv;
        logic       er;
    } rx_pins_s;

    typedef struct packed {
        logic [3:0] nib;
        logic       er;
    } rx_word_s;
endpackage : phy_timing_pkg

// *** testbench/mac_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host controller model: transmit nibbles, management clock
// ----------------------------------------------------------------
module mac_host_model
    import phy_timing_pkg::*;
(
    input  wire logic clk,
    input  wire logic tx_clk,
    output tx_pins_s  tx_in,
    output logic      mdc
);
    logic clk_q = 1'b0;
    logic exp_q[$];

    // idle levels from time zero
    initial begin
        tx_in = '0;
        mdc = 1'b0;
    end

    // host clock level one edge back
    always @(posedge clk) begin
        clk_q <= tx_clk;
    end

    // one nibble after a clock rise, held for the whole period
    task automatic send_nib(input logic [3:0] d, input logic en, input logic er,
                            input logic ser);
        @(posedge clk);
        while (!(tx_clk && !clk_q)) @(posedge clk);
        tx_in <= '{txd: d, en: en, er: er};
        if (en && ser)
            exp_q.push_back(d[0]);
        for (int k = 0; k < 4; k++)
            if (en && !ser)
                exp_q.push_back(er ? 1'b1 : d[k]);
    endtask : send_nib

    // management clock burst on clock edges, low between bursts
    task automatic mdc_run(input int hi, input int lo, input int n);
        repeat (n) begin
            mdc <= 1'b1;
            repeat (hi / CLK_NS) @(posedge clk);
            mdc <= 1'b0;
            repeat (lo / CLK_NS) @(posedge clk);
        end
    endtask : mdc_run
endmodule : mac_host_model

// *** testbench/phy_mii_clock_latency_tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module phy_mii_clock_latency_tb
    import phy_timing_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [1:0]  mode = 2'h0;
    logic        rx_stall = 1'b0;
    logic        lrx = 1'b0;
    logic        lrx_act = 1'b0;
    logic        rx_busy = 1'b0;
    logic        lrx_d = 1'b0;
    logic        tx_clk, rx_clk, ltx, ltx_act, fifo_rdy, mdc, mdc_err;
    tx_pins_s    tx_in;
    rx_pins_s    rx_out;
    rx_pins_s    rxo_q = '0;
    int          miscompares = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          cpb, per, lat_lo, lat_hi, rises, t_rise, t_en, t_act, nb, t_line, t_mark;
    logic [31:0] rng = 32'h2a;
    logic        rx_q[$];
    logic        per_on = 0, rx_on = 0, en_seen, mk, sy, dv_seen, ser_done, er_seen = 0;
    logic        ck_q = 0, act_q = 0, arx_q = 0;
    int          per_t[4] = '{40 / 10, 400 / 10, 40 / 10, 100 / 10};
    int          cpb_t[4] = '{1, 10, 1, 10};
    int          lo_t[4]  = '{0, 0, 0, 80};
    int          hi_t[4]  = '{3, 20, 7, 90};

    phy_mii_timing uut (
        .CLK(clk), .SRST(srst), .MODE(mode), .TX_CLK(tx_clk), .RX_CLK(rx_clk),
        .TX_IN(tx_in), .RX_OUT(rx_out), .RX_STALL(rx_stall), .RX_FIFO_READY(fifo_rdy),
        .LINE_RECEIVE_PAIR(lrx), .LINE_RX_ACTIVE(lrx_act), .LINE_TRANSMIT_PAIR(ltx),
        .LINE_TX_ACTIVE(ltx_act), .MDC(mdc), .MDC_TIMING_ERR(mdc_err)
    );
    mac_host_model mac (.clk(clk), .tx_clk(tx_clk), .tx_in(tx_in), .mdc(mdc));

    // clock source
    initial begin
        forever #5 clk = ~clk;
    end

    // line drive: frame data, toggling while idle
    always @(posedge clk) begin
        lrx_act <= rx_busy;
        lrx     <= rx_busy ? lrx_d : ~lrx;
    end

    // cycle count and hang cut-off
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic end_sim();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic set_mode(input int m);
        mode <= 2'(m);
        per_on = 1'b0;
        cpb = cpb_t[m];
        per = per_t[m];
        lat_lo = lo_t[m];
        lat_hi = hi_t[m];
        repeat (100) @(posedge clk);
        rises = 0;
        per_on = 1'b1;
    endtask : set_mode

    // quiet zeros, one marker bit, then n random bits noted in the queue
    task automatic line_frame(input int n);
        rx_busy <= 1'b1;
        lrx_d <= 1'b0;
        repeat (8 * cpb) @(posedge clk);
        lrx_d <= 1'b1;
        repeat (cpb) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rng = xs(rng);
            lrx_d <= rng[0];
            rx_q.push_back(rng[0]);
            repeat (cpb) @(posedge clk);
        end
        rx_busy <= 1'b0;
    endtask : line_frame

    task automatic run_mode(input int m);
        set_mode(m);
        en_seen = 1'b0;
        for (int i = 0; i < 7; i++) begin
            rng = xs(rng);
            mac.send_nib(rng[3:0], i < 6, i == 2 && m != 3, m == 3);
        end
        // serial line lags eight bits: wait for the frame to start, then end
        for (int k = 0; k < 300 && !ltx_act; k++) @(posedge clk);
        for (int k = 0; k < 300 && ltx_act; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk(mac.exp_q.size() == 0, "line bits missing");
        rx_on = 1'b1;
        line_frame(40);
        repeat (12 * cpb) @(posedge clk);
        if (m != 3)
            chk(rx_q.size() <= 3 && sy === 1'b1, "receive bits missing");
        else
            chk(ser_done === 1'b1, "serial receive bit missing");
        rx_q.delete();
        rx_on = 1'b0;
    endtask : run_mode

    // ----------------------------------------------------------------
    // output watcher: clocks, line bits, receive nibbles
    // ----------------------------------------------------------------
    always @(negedge clk) begin
        if (!srst) begin
            chk(tx_clk === rx_clk, "clock pair");
            if (rx_clk && !ck_q) begin
                if (per_on && rises > 0)
                    chk(cyc - t_rise == per, "clock period");
                t_rise = cyc;
                rises++;
                if (tx_in.en && !en_seen) begin
                    en_seen = 1'b1;
                    t_en = cyc;
                end
                if (per_on && mode != 2'h3)
                    chk(rx_out === rxo_q, "receive pins moved at rise");
                er_seen = er_seen | (rx_out.dv & rx_out.er);
                if (rx_on && rx_out.dv && mode != 2'h3)
                    for (int k = 0; k < 4; k++)
                        if (!sy)
                            sy = rx_out.rxd[k];
                        else if (rx_q.size() > 0)
                            chk(rx_out.rxd[k] === rx_q.pop_front(), "receive bit");
            end
            if (ltx_act && !act_q) begin
                t_act = cyc;
                nb = 0;
                chk(cyc - t_en >= lat_lo && cyc - t_en <= lat_hi, "transmit latency");
            end
            if (ltx_act && cyc - t_act == nb * cpb + cpb / 2) begin
                nb++;
                if (mac.exp_q.size() == 0)
                    chk(1'b0, "extra line bit");
                else
                    chk(ltx === mac.exp_q.pop_front(), "line bit");
            end
            if (lrx_act && !arx_q) begin
                t_line = cyc;
                mk = 1'b0;
                sy = 1'b0;
                dv_seen = 1'b0;
                ser_done = 1'b0;
            end
            if (lrx_act && lrx && !mk) begin
                mk = 1'b1;
                t_mark = cyc;
            end
            if (rx_on && rx_out.dv === 1'b1 && !dv_seen) begin
                dv_seen = 1'b1;
                if (mode == 2'h1)
                    chk(cyc - t_line <= 70, "first nibble late");
            end
            if (mode == 2'h3 && mk && !ser_done && rx_out.dv && rx_out.rxd[0]) begin
                ser_done = 1'b1;
                chk(cyc - t_mark <= 40, "serial receive late");
            end
        end
        ck_q = rx_clk;
        act_q = ltx_act;
        arx_q = lrx_act;
        rxo_q = rx_out;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (int m = 0; m < 4; m++)
            run_mode(m);
        set_mode(0);
        rx_stall <= 1'b1;
        fork
            line_frame(300);
            begin
                repeat (200) @(posedge clk);
                chk(fifo_rdy === 1'b0 && rx_out.dv === 1'b0, "buffer not full");
                rx_stall <= 1'b0;
            end
        join
        repeat (200) @(posedge clk);
        chk(fifo_rdy === 1'b1 && er_seen === 1'b1, "buffer drain");
        rx_q.delete();
        mac.mdc_run(160, 240, 6);
        repeat (50) @(posedge clk);
        chk(mdc_err === 1'b0, "legal management clock flagged");
        mac.mdc_run(80, 80, 6);
        repeat (50) @(posedge clk);
        chk(mdc_err === 1'b1, "short management clock missed");
        per_on = 1'b0;
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (5) @(posedge clk);
        chk(mdc_err === 1'b0 && rx_out === '0, "state after reset");
        end_sim();
    end
endmodule : phy_mii_clock_latency_tb

// *** verilog/phy_mii_timing.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// receive word buffer
// ----------------------------------------------------------------
module rx_word_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two");
    end

    // honest full and empty
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : rx_word_fifo

// ----------------------------------------------------------------
// host clocks, latencies and line path
// ----------------------------------------------------------------
module phy_mii_timing
    import phy_timing_pkg::*;
#(
    parameter int RX_FIFO_DEPTH = FIFO_DEPTH
) (
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic [1:0] MODE,
    output logic            TX_CLK,
    output logic            RX_CLK,
    input  tx_pins_s        TX_IN,
    output rx_pins_s        RX_OUT,
    input  wire logic       RX_STALL,
    output logic            RX_FIFO_READY,
    input  wire logic       LINE_RECEIVE_PAIR,
    input  wire logic       LINE_RX_ACTIVE,
    output logic            LINE_TRANSMIT_PAIR,
    output logic            LINE_TX_ACTIVE,
    input  wire logic       MDC,
    output logic            MDC_TIMING_ERR
);
    localparam int ASYNC_W = 6 + $bits(tx_pins_s);
    localparam int PH_W    = $clog2(CPB_SLOW);

    logic [ASYNC_W-1:0] s1_q;
    logic [ASYNC_W-1:0] s2_q;
    logic [1:0]         mode_raw;
    tx_pins_s           tx_s;
    logic               line_rx;
    logic               line_act;
    logic               stall;
    logic               mdc_s;
    mode_e              mode;
    mode_e              mode_q;
    logic               mode_chg;
    logic               slow;
    logic               ser;
    logic               nib_mode;
    logic [PH_W-1:0]    cpb_m1;
    logic [PH_W-1:0]    bph_q;
    logic [1:0]         bidx_q;
    logic               bit_tick;
    logic               clk_d;
    logic               clk_q;
    logic               rise_q;
    logic               take_q;
    logic [3:0]         tx_nib;
    logic [2:0]         sh_q;
    logic [PH_W-1:0]    tph_q;
    logic               line_q;
    logic               lact_q;
    logic [1:0]         dly_q [SER_TX_DLY_BT];
    logic               serial_rx_bit;
    logic               serial_tx_bit;
    logic               serial_tx_enable;
    logic [2:0]         nib_q;
    logic               seen_q;
    logic               ovf_q;
    rx_word_s           wr_word;
    rx_word_s           rd_word;
    logic               push_v;
    logic               push_rdy;
    logic               rd_valid;
    logic               pop;
    rx_pins_s           rx_q;
    logic               mdc_d_q;
    logic [7:0]         mcnt_q;
    logic [7:0]         mper_q;
    logic               merr_q;

    if (PER_NS_MII_F != BITS_PER_NIB * BIT_NS_FAST || BITS_PER_NIB != 4 ||
        PER_NS_MII_S != BITS_PER_NIB * BIT_NS_SLOW ||
        PER_NS_SYM_F != BITS_PER_NIB * BIT_NS_FAST ||
        PER_NS_SER_S != BIT_NS_SLOW || CPB_FAST != 1) begin : g_chk
        $error("clock periods do not fit the divider");
    end

    // two-stage capture of every outside input apart from CLK and SRST
    always_ff @(posedge CLK) begin
        if (SRST) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {MODE, TX_IN, LINE_RECEIVE_PAIR, LINE_RX_ACTIVE, RX_STALL, MDC};
            s2_q <= s1_q;
        end
    end

    assign {mode_raw, tx_s, line_rx, line_act, stall, mdc_s} = s2_q;
    assign mode     = mode_e'(mode_raw);
    assign ser      = (mode == MODE_SER_SLOW);
    assign slow     = ser || (mode == MODE_MII_SLOW);
    assign nib_mode = !ser;

    // mode one cycle back, marks the cycle of a mode switch
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_q <= MODE_MII_FAST;
        end else begin
            mode_q <= mode;
        end
    end

    assign mode_chg = (mode != mode_q);

    // ------------------------------------------------------------
    // bit-time divider and host clocks
    // ------------------------------------------------------------
    assign cpb_m1   = slow ? PH_W'(CPB_SLOW - 1) : PH_W'(CPB_FAST - 1);
    assign bit_tick = (bph_q >= cpb_m1); // slow phase left over ends at once

    // bit phase and bit-in-nibble index
    always_ff @(posedge CLK) begin
        if (SRST) begin
            bph_q  <= '0;
            bidx_q <= '0;
        end else if (bit_tick) begin
            bph_q  <= '0;
            bidx_q <= bidx_q + 2'd1;
        end else begin
            bph_q  <= bph_q + 1'b1;
        end
    end

    // nibble clock spans four bits, serial clock one bit
    assign clk_d = ser ? (bph_q >= PH_W'(CPB_SLOW / 2)) : bidx_q[1];

    // clock register and tx sampling point
    always_ff @(posedge CLK) begin
        if (SRST) begin
            clk_q  <= 1'b0;
            rise_q <= 1'b0;
            take_q <= 1'b0;
        end else begin
            clk_q  <= clk_d;
            rise_q <= clk_d & ~clk_q;
            take_q <= rise_q;
        end
    end

    assign TX_CLK = clk_q;
    assign RX_CLK = clk_q;

    // ------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------
    assign tx_nib           = (tx_s.en & tx_s.er) ? ERR_NIB : tx_s.txd;
    assign serial_tx_bit    = tx_s.txd[0];
    assign serial_tx_enable = tx_s.en;

    // serial delay line, one stage per bit time
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int i = 0; i < SER_TX_DLY_BT; i++) begin
                dly_q[i] <= '0;
            end
        end else if (ser && take_q) begin
            dly_q[0] <= {serial_tx_enable, serial_tx_bit};
            for (int i = 1; i < SER_TX_DLY_BT; i++) begin
                dly_q[i] <= dly_q[i-1];
            end
        end
    end

    // nibble serialiser, low bit first
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sh_q   <= '0;
            tph_q  <= '0;
            line_q <= 1'b0;
            lact_q <= 1'b0;
        end else if (ser) begin
            if (take_q) begin
                line_q <= dly_q[SER_TX_DLY_BT-1][0];
                lact_q <= dly_q[SER_TX_DLY_BT-1][1];
            end
        end else if (take_q) begin
            line_q <= tx_nib[0];
            lact_q <= tx_s.en;
            sh_q   <= tx_nib[3:1];
            tph_q  <= '0;
        end else if (tph_q == cpb_m1) begin
            line_q <= sh_q[0];
            sh_q   <= {1'b0, sh_q[2:1]};
            tph_q  <= '0;
        end else begin
            tph_q  <= tph_q + 1'b1;
        end
    end

    assign LINE_TRANSMIT_PAIR = line_q;
    assign LINE_TX_ACTIVE     = lact_q;

    // ------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------
    assign serial_rx_bit = line_rx & line_act;

    // nibble assembly aligned to the clock phase
    always_ff @(posedge CLK) begin
        if (SRST) begin
            nib_q  <= '0;
            seen_q <= 1'b0;
        end else if (nib_mode && bit_tick) begin
            if (bidx_q == 2'd3) begin
                nib_q  <= '0;
                seen_q <= 1'b0;
            end else begin
                nib_q  <= nib_q | (3'(serial_rx_bit) << bidx_q);
                seen_q <= seen_q | line_act;
            end
        end
    end

    assign push_v  = nib_mode & bit_tick & (bidx_q == 2'd3) & (seen_q | line_act);
    assign wr_word = '{nib: {serial_rx_bit, nib_q}, er: ovf_q};

    // refused word marks the next one as errored
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ovf_q <= 1'b0;
        end else if (push_v) begin
            ovf_q <= ~push_rdy;
        end
    end

    rx_word_fifo #(
        .WIDTH ($bits(rx_word_s)),
        .DEPTH (RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (CLK),
        .srst      (SRST),
        .in_valid  (push_v),
        .in_ready  (push_rdy),
        .in_data   (wr_word),
        .out_valid (rd_valid),
        .out_ready (pop),
        .out_data  (rd_word)
    );

    assign RX_FIFO_READY = push_rdy;
    assign pop = nib_mode & bit_tick & (bidx_q == 2'd0) & rd_valid & ~stall;

    // nibble-mode host outputs change while the clock is low, the serial bit while it is high
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rx_q <= '0;
        end else if (ser && bit_tick) begin
            rx_q <= '{rxd: {3'h0, serial_rx_bit}, dv: line_act, er: 1'b0};
        end else if (nib_mode && bit_tick && bidx_q == 2'd0) begin
            rx_q <= pop ? '{rxd: rd_word.nib, dv: 1'b1, er: rd_word.er} : '0;
        end
    end

    assign RX_OUT = rx_q;

    // ------------------------------------------------------------
    // management clock monitor
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mdc_d_q <= 1'b0;
            mcnt_q  <= 8'hff;
            mper_q  <= 8'hff;
            merr_q  <= 1'b0;
        end else begin
            mdc_d_q <= mdc_s;
            mcnt_q  <= (mdc_s != mdc_d_q) ? 8'h01 : mcnt_q + {7'h00, mcnt_q != 8'hff};
            mper_q  <= (mdc_s & ~mdc_d_q) ? 8'h01 : mper_q + {7'h00, mper_q != 8'hff};
            if (~mdc_s & mdc_d_q & (mcnt_q < 8'(MDC_HI_CYC))) begin
                merr_q <= 1'b1;
            end
            if (mdc_s & ~mdc_d_q &
                ((mcnt_q < 8'(MDC_LO_CYC)) | (mper_q < 8'(MDC_PER_CYC)))) begin
                merr_q <= 1'b1;
            end
        end
    end

    assign MDC_TIMING_ERR = merr_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_clk_rise;
        $rose(clk_q);
    endsequence

    sequence s_slow_frame;
        nib_mode && slow && !stall && $rose(line_act);
    endsequence

    AST_RXCLK_MII_FAST: assert property (@(posedge CLK) disable iff (SRST || mode_chg)
        (mode == MODE_MII_FAST && !mode_chg) ##0 s_clk_rise |-> ##4 $rose(clk_q))
        else $error("fast MII clock period wrong");

    AST_RXCLK_MII_SLOW: assert property (@(posedge CLK) disable iff (SRST || mode_chg)
        (mode == MODE_MII_SLOW && !mode_chg) ##0 s_clk_rise |-> ##40 $rose(clk_q))
        else $error("slow MII clock period wrong");

    AST_RXCLK_SYM: assert property (@(posedge CLK) disable iff (SRST || mode_chg)
        (mode == MODE_SYM_FAST && !mode_chg) ##0 s_clk_rise |-> ##4 $rose(clk_q))
        else $error("symbol clock period wrong");

    AST_RXCLK_SER: assert property (@(posedge CLK) disable iff (SRST || mode_chg)
        (mode == MODE_SER_SLOW && !mode_chg) ##0 s_clk_rise |-> ##10 $rose(clk_q))
        else $error("serial clock period wrong");

    AST_TX_TAKE: assert property (@(posedge CLK) disable iff (SRST)
        s_clk_rise |-> ##1 take_q)
        else $error("tx pins not taken after clock rise");

    AST_RX_STABLE: assert property (@(posedge CLK) disable iff (SRST)
        nib_mode ##0 s_clk_rise |-> $stable(rx_q) ##1 $stable(rx_q))
        else $error("rx pins move at clock rise");

    property p_ser_rx;
        logic b;
        (ser && bit_tick, b = serial_rx_bit) |-> ##1 (rx_q.rxd[0] == b);
    endproperty
    AST_SER_RX_LAT: assert property (@(posedge CLK) disable iff (SRST) p_ser_rx)
        else $error("serial rx bit late");

    AST_MII_SLOW_RX_LAT: assert property (@(posedge CLK) disable iff (SRST || mode_chg)
        s_slow_frame |-> ##[1:66] rx_q.dv)
        else $error("first slow nibble late");

    property p_ser_tx;
        logic b;
        (ser && take_q, b = serial_tx_bit) |-> ##81 (line_q == b);
    endproperty
    AST_SER_TX_LAT: assert property (@(posedge CLK) disable iff (SRST || mode_chg) p_ser_tx)
        else $error("serial tx delay not eight bits");

    property p_mii_slow_tx;
        logic b;
        (mode == MODE_MII_SLOW && take_q, b = tx_nib[0]) |-> ##1 (line_q == b);
    endproperty
    AST_MII_SLOW_TX: assert property (@(posedge CLK) disable iff (SRST) p_mii_slow_tx)
        else $error("slow MII first bit late");

    AST_MII_FAST_TX: assert property (@(posedge CLK) disable iff (SRST)
        (mode == MODE_MII_FAST && take_q && tx_s.en) |-> ##[1:3] lact_q)
        else $error("fast MII delimiter late");

    AST_SYM_TX: assert property (@(posedge CLK) disable iff (SRST)
        (mode == MODE_SYM_FAST && take_q && tx_s.en) |-> ##[1:7] lact_q)
        else $error("stream delimiter late");

    AST_MDC_SHORT_HIGH: assert property (@(posedge CLK) disable iff (SRST)
        (mdc_d_q && !mdc_s && mcnt_q < 8'(MDC_HI_CYC)) |-> ##1 merr_q)
        else $error("short management clock high not flagged");

    AST_BIT_SLOW: assert property (@(posedge CLK) disable iff (SRST || mode_chg)
        (slow && bit_tick && $stable(mode)) |->
            ##1 (!bit_tick)[*8] ##1 !bit_tick ##1 bit_tick)
        else $error("slow bit time not ten cycles");

    AST_BIT_FAST: assert property (@(posedge CLK) disable iff (SRST)
        (!slow && $stable(mode)) |-> bit_tick)
        else $error("fast bit time not one cycle");
endmodule : phy_mii_timing
